// [hdl/asal_top.sv]
// Status output, remote calibration and alarm relay logic of a gas
// analyzer. Assumes a single clock, synchronous inputs, and that the
// measurement core supplies fault, warning, concentration and range.
//
// Behaviour
// - health_good is on only while no fault is present.
// - reading_trustworthy off during holdoff, calibration or invalidating fault.
// - reading_trustworthy on when the measurement is judged valid.
// - upper_scale_flag on in upper range under twin or automatic range.
// - Trim and service outputs follow baseline, gain and diagnostic modes.
// - Remote baseline request enters baseline calibration, flagged remote.
// - Remote gain request enters midpoint gain calibration, flagged remote.
// - Health relay energized while healthy and no warning active.
// - Health relay drops on any warning or in diagnostic mode.
// - With both route bits clear, relay two follows first set point, relay three the second.
// - Concentration relays follow the comparison without latching.
// - Front-panel warning latches on crossing until explicitly cleared.
// - Warning clears by clear_key or by remote serial clear command.
// - Two enableable alarm levels, each routable to either relay.
// - Range relay follows range bit under automatic range select.
`timescale 1ns/10ps
module asal_top
  import asal_pkg::*;
#(
  parameter int CW       = 16,
  parameter int DEB_CYC  = ASAL_DEBOUNCE_CYC
)
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Measurement core.
  input  wire logic          fault_any,
  input  wire logic          invalid_fault,
  input  wire logic          warning_any,
  input  wire logic          validity_holdoff,
  input  wire logic          reading_valid,
  input  wire logic          upper_range,
  input  wire logic [CW-1:0] concentration,
  input  wire logic          local_base_cal,
  input  wire logic          local_gain_cal,
  input  wire logic          cal_done,
  // Operator and remote party.
  input  wire logic          clear_key,
  input  wire logic          remote_baseline_request,
  input  wire logic          remote_gain_request,
  // Register port.
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  // Outputs.
  output asal_status_t       status,
  output asal_relay_t        relays,
  output logic               panel_warning,
  output logic               cal_remote,
  output logic               irq
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]    ctrl_q, ctrl_d;
  logic [CW-1:0] set1_q, set1_d;
  logic [CW-1:0] set2_q, set2_d;
  logic [3:0]    ist_q, ist_d;
  logic [3:0]    imk_q, imk_d;
  logic [31:0]   rdata_q, rdata_d;
  logic          irq_q, irq_d;
  logic          serial_clear;

  // Serial-port clear command arrives as a write to the clear register.
  assign serial_clear = reg_wr && (reg_addr == ASAL_ADDR_CLEAR) && reg_wdata[0];

  // ---------------------------------------------------------------
  // Remote request conditioning
  // ---------------------------------------------------------------
  logic rb_lvl, rb_rise, rg_lvl, rg_rise;

  asal_debounce #(.COUNT(DEB_CYC)) u_deb_base (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (remote_baseline_request),
    .dout    (rb_lvl),
    .rise    (rb_rise)
  );

  asal_debounce #(.COUNT(DEB_CYC)) u_deb_gain (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (remote_gain_request),
    .dout    (rg_lvl),
    .rise    (rg_rise)
  );

  // ---------------------------------------------------------------
  // Calibration mode
  // ---------------------------------------------------------------
  asal_cal_t cal_q, cal_d;
  logic      remote_q, remote_d;

  // Baseline wins if both requests rise together; a remote request held
  // high keeps the mode until it drops, a local one until cal_done.
  always_comb
  begin
    cal_d    = cal_q;
    remote_d = remote_q;
    unique case (cal_q)
      ASAL_CAL_NONE:
      begin
        if (rb_rise)
        begin
          cal_d    = ASAL_CAL_BASE;
          remote_d = 1'b1;
        end
        else if (rg_rise)
        begin
          cal_d    = ASAL_CAL_GAIN;
          remote_d = 1'b1;
        end
        else if (local_base_cal)
        begin
          cal_d    = ASAL_CAL_BASE;
          remote_d = 1'b0;
        end
        else if (local_gain_cal)
        begin
          cal_d    = ASAL_CAL_GAIN;
          remote_d = 1'b0;
        end
      end
      ASAL_CAL_BASE:
      begin
        if (remote_q ? !rb_lvl : cal_done)
        begin
          cal_d    = ASAL_CAL_NONE;
          remote_d = 1'b0;
        end
      end
      ASAL_CAL_GAIN:
      begin
        if (remote_q ? !rg_lvl : cal_done)
        begin
          cal_d    = ASAL_CAL_NONE;
          remote_d = 1'b0;
        end
      end
      default:
      begin
        cal_d    = ASAL_CAL_NONE;
        remote_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cal_q    <= ASAL_CAL_NONE;
      remote_q <= 1'b0;
    end
    else
    begin
      cal_q    <= cal_d;
      remote_q <= remote_d;
    end
  end

  // ---------------------------------------------------------------
  // Concentration alarms
  // ---------------------------------------------------------------
  logic lvl1, lvl2;
  logic warn_q, warn_d;

  asal_thresh #(.W(CW)) u_lvl1 (
    .enable   (ctrl_q[ASAL_CTRL_EN1]),
    .conc     (concentration),
    .setpoint (set1_q),
    .above    (lvl1)
  );

  asal_thresh #(.W(CW)) u_lvl2 (
    .enable   (ctrl_q[ASAL_CTRL_EN2]),
    .conc     (concentration),
    .setpoint (set2_q),
    .above    (lvl2)
  );

  // A route bit of 0 puts a level on its own relay, 1 on the other, so
  // both levels may share one relay or be split.
  logic r2_on, r3_on;
  always_comb
  begin
    r2_on = (lvl1 & ~ctrl_q[ASAL_CTRL_ROUTE1]) |
            (lvl2 &  ctrl_q[ASAL_CTRL_ROUTE2]);
    r3_on = (lvl2 & ~ctrl_q[ASAL_CTRL_ROUTE2]) |
            (lvl1 &  ctrl_q[ASAL_CTRL_ROUTE1]);
    // A new crossing wins over a clear in the same cycle.
    warn_d = (lvl1 | lvl2) ? 1'b1 :
             ((clear_key | serial_clear) ? 1'b0 : warn_q);
  end

  // ---------------------------------------------------------------
  // Status outputs and relays
  // ---------------------------------------------------------------
  asal_status_t st_d;
  asal_relay_t  rl_d;
  logic         range_mode;

  assign range_mode = ctrl_q[ASAL_CTRL_AUTO_RANGE] | ctrl_q[ASAL_CTRL_TWIN_RANGE];

  always_comb
  begin
    st_d.health_good          = ~fault_any;
    st_d.reading_trustworthy  = reading_valid & ~validity_holdoff &
                                (cal_q == ASAL_CAL_NONE) &
                                ~invalid_fault;
    st_d.upper_scale_flag     = range_mode & upper_range;
    st_d.baseline_trim_active = (cal_q == ASAL_CAL_BASE);
    st_d.gain_trim_active     = (cal_q == ASAL_CAL_GAIN);
    st_d.service_test_active  = ctrl_q[ASAL_CTRL_SERVICE];
    rl_d.health_relay = ~fault_any & ~warning_any & ~warn_d &
                        ~ctrl_q[ASAL_CTRL_SERVICE];
    rl_d.conc_relay1  = r2_on;
    rl_d.conc_relay2  = r3_on;
    rl_d.range_relay  = ctrl_q[ASAL_CTRL_AUTO_RANGE] & upper_range;
  end

  // ---------------------------------------------------------------
  // Register port and interrupt
  // ---------------------------------------------------------------
  // Events: fault onset, warning latch, remote baseline, remote gain.
  logic [3:0] ev;
  // Fault onset compares against the registered health flag, so a fault
  // already present in the first cycle after reset raises no event.
  assign ev = {(cal_d == ASAL_CAL_GAIN) & remote_d & (cal_q != ASAL_CAL_GAIN),
               (cal_d == ASAL_CAL_BASE) & remote_d & (cal_q != ASAL_CAL_BASE),
               warn_d & ~warn_q,
               fault_any & status.health_good};

  always_comb
  begin
    ctrl_d  = ctrl_q;
    set1_d  = set1_q;
    set2_d  = set2_q;
    imk_d   = imk_q;
    ist_d   = ist_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ASAL_ADDR_CTRL:   ctrl_d = reg_wdata[7:0];
        ASAL_ADDR_SET1:   set1_d = reg_wdata[CW-1:0];
        ASAL_ADDR_SET2:   set2_d = reg_wdata[CW-1:0];
        ASAL_ADDR_IRQ_ST: ist_d  = ist_q & ~reg_wdata[3:0];
        ASAL_ADDR_IRQ_MK: imk_d  = reg_wdata[3:0];
        default:          ctrl_d = ctrl_q;
      endcase
    end
    ist_d = ist_d | ev;  // Set wins over a write-one clear.
    if (reg_rd)
    begin
      unique case (reg_addr)
        ASAL_ADDR_CTRL:   rdata_d = {24'h000000, ctrl_q};
        ASAL_ADDR_SET1:   rdata_d = 32'(set1_q);
        ASAL_ADDR_SET2:   rdata_d = 32'(set2_q);
        ASAL_ADDR_STATE:  rdata_d = {20'h00000, relays, warn_q, remote_q,
                                     status[5:0]};
        ASAL_ADDR_IRQ_ST: rdata_d = {28'h0000000, ist_q};
        ASAL_ADDR_IRQ_MK: rdata_d = {28'h0000000, imk_q};
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(ist_d & imk_d);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q        <= ASAL_CTRL_RST;
      set1_q        <= ASAL_SET_RST[CW-1:0];
      set2_q        <= ASAL_SET_RST[CW-1:0];
      ist_q         <= 4'h0;
      imk_q         <= ASAL_MASK_RST;
      rdata_q       <= 32'h0000_0000;
      irq_q         <= 1'b0;
      warn_q        <= 1'b0;
      status        <= '0;
      relays        <= '0;
    end
    else
    begin
      ctrl_q        <= ctrl_d;
      set1_q        <= set1_d;
      set2_q        <= set2_d;
      ist_q         <= ist_d;
      imk_q         <= imk_d;
      rdata_q       <= rdata_d;
      irq_q         <= irq_d;
      warn_q        <= warn_d;
      status        <= st_d;
      relays        <= rl_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign irq           = irq_q;
  assign panel_warning = warn_q;
  assign cal_remote    = remote_q;

endmodule

// [hdl/asal_pkg.sv]
// Package for the analyzer status and alarm logic.
// Assumes a single 250 MHz clock domain and synchronous inputs.
package asal_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ASAL_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ASAL_ADDR_SET1   = 4'h1;
  localparam logic [3:0] ASAL_ADDR_SET2   = 4'h2;
  localparam logic [3:0] ASAL_ADDR_STATE  = 4'h3;
  localparam logic [3:0] ASAL_ADDR_IRQ_ST = 4'h4;
  localparam logic [3:0] ASAL_ADDR_IRQ_MK = 4'h5;
  localparam logic [3:0] ASAL_ADDR_CLEAR  = 4'h6;

  // Control register field positions.
  localparam int ASAL_CTRL_AUTO_RANGE = 0;
  localparam int ASAL_CTRL_TWIN_RANGE = 1;
  localparam int ASAL_CTRL_SERVICE    = 2;
  localparam int ASAL_CTRL_EN1        = 3;
  localparam int ASAL_CTRL_EN2        = 4;
  localparam int ASAL_CTRL_ROUTE1     = 5;
  localparam int ASAL_CTRL_ROUTE2     = 6;
  localparam int ASAL_CTRL_UPPER_SEL  = 7;

  // Reset values.
  localparam logic [7:0]  ASAL_CTRL_RST = 8'h00;
  localparam logic [15:0] ASAL_SET_RST  = 16'hFFFF;
  localparam logic [3:0]  ASAL_MASK_RST = 4'h0;

  // Debounce time and cycles at 250 MHz.
  localparam int ASAL_CLK_MHZ      = 250;
  localparam int ASAL_DEBOUNCE_US  = 1;
  localparam int ASAL_DEBOUNCE_CYC = ASAL_DEBOUNCE_US * ASAL_CLK_MHZ;

  // Interrupt event bit positions.
  localparam int ASAL_EV_FAULT = 0;
  localparam int ASAL_EV_WARN  = 1;
  localparam int ASAL_EV_RBASE = 2;
  localparam int ASAL_EV_RGAIN = 3;

  // Calibration modes.
  typedef enum logic [1:0] {
    ASAL_CAL_NONE = 2'b00,
    ASAL_CAL_BASE = 2'b01,
    ASAL_CAL_GAIN = 2'b10
  } asal_cal_t;

  // Discrete status outputs travelling together.
  typedef struct packed {
    logic health_good;
    logic reading_trustworthy;
    logic upper_scale_flag;
    logic baseline_trim_active;
    logic gain_trim_active;
    logic service_test_active;
  } asal_status_t;

  // Relay drive group.
  typedef struct packed {
    logic health_relay;
    logic conc_relay1;
    logic conc_relay2;
    logic range_relay;
  } asal_relay_t;

endpackage

// [hdl/asal_debounce.sv]
// Two-flop synchroniser followed by a stability debouncer.
// Assumes one clock; output changes only after a stable input run.
`timescale 1ns/10ps
module asal_debounce
  import asal_pkg::*;
#(
  parameter int COUNT = ASAL_DEBOUNCE_CYC
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout,
  output logic      rise
);

  localparam int CW = $clog2(COUNT + 1);

  logic          s1_q;
  logic          s2_q;
  logic          out_q;
  logic          out_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // ---------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------
  // The count restarts whenever the synced level matches the output,
  // so a glitch shorter than the window never reaches the mode logic.
  always_comb
  begin
    out_d = out_q;
    cnt_d = '0;
    if (s2_q != out_q)
    begin
      if (cnt_q == CW'(COUNT - 1))
        out_d = s2_q;
      else
        cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      s1_q  <= din;
      s2_q  <= s1_q;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign dout = out_q;
  assign rise = out_d & ~out_q;  // One pulse per clean assertion.

endmodule

// [hdl/asal_thresh.sv]
// One concentration set point comparator with enable.
// Assumes concentration and set point share one unsigned scale.
`timescale 1ns/10ps
module asal_thresh #(
  parameter int W = 16
)
(
  input  wire logic         enable,
  input  wire logic [W-1:0] conc,
  input  wire logic [W-1:0] setpoint,
  output logic              above
);

  // A disabled level never trips, whatever its set point holds.
  assign above = enable & (conc > setpoint);

endmodule

// [tb/asal_top_monitor.sv]
// Concurrent checks on the status, relay and warning ports of asal_top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
module asal_top_monitor
  import asal_pkg::*;
#(
  parameter int CW      = 16,
  parameter int DEB_CYC = ASAL_DEBOUNCE_CYC
)
(
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         fault_any,
  input wire logic         invalid_fault,
  input wire logic         warning_any,
  input wire logic         validity_holdoff,
  input wire logic         reading_valid,
  input wire logic         upper_range,
  input wire logic         clear_key,
  input wire logic         remote_baseline_request,
  input wire logic         remote_gain_request,
  input wire logic [3:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_wr,
  input wire asal_status_t status,
  input wire asal_relay_t  relays,
  input wire logic         panel_warning,
  input wire logic         cal_remote
);
  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // A serial clear is a write of one to bit zero of the clear address.
  logic ser_clear;
  assign ser_clear = reg_wr && (reg_addr == ASAL_ADDR_CLEAR) && reg_wdata[0];

  health_follow_a: assert property ($past(reset_n) |->
    status.health_good == !$past(fault_any)) else $error("health flag wrong");
  trust_drop_a: assert property ($past(reset_n) &&
    $past(validity_holdoff || invalid_fault) |-> !status.reading_trustworthy)
    else $error("trustworthy flag stayed on");
  trust_rise_a: assert property ($past(reset_n) && $past(reading_valid &&
    !validity_holdoff && !invalid_fault && !status.baseline_trim_active &&
    !status.gain_trim_active) && !status.baseline_trim_active &&
    !status.gain_trim_active |-> status.reading_trustworthy)
    else $error("trustworthy flag missing");
  upper_cause_a: assert property ($past(reset_n) && $past(!upper_range)
    |-> !status.upper_scale_flag) else $error("upper flag without range");
  range_relay_a: assert property (relays.range_relay |->
    status.upper_scale_flag && $past(upper_range)) else $error("range relay wrong");
  remote_mode_a: assert property (cal_remote |=>
    status.baseline_trim_active ^ status.gain_trim_active)
    else $error("remote flag without one trim mode");
  health_drop_a: assert property (status.service_test_active || panel_warning ||
    ($past(reset_n) && $past(warning_any)) |-> !relays.health_relay)
    else $error("health relay stayed energized");
  health_hold_a: assert property ($past(reset_n) &&
    $past(!fault_any && !warning_any) && !panel_warning &&
    !status.service_test_active |-> relays.health_relay)
    else $error("health relay dropped while healthy");
  warn_set_a: assert property ($rose(relays.conc_relay1) ||
    $rose(relays.conc_relay2) |-> panel_warning) else $error("warning not set");
  warn_hold_a: assert property (panel_warning && !clear_key && !ser_clear
    |=> panel_warning) else $error("warning lost without clear");
  warn_clear_a: assert property (clear_key || ser_clear |=> !panel_warning ||
    relays.conc_relay1 || relays.conc_relay2) else $error("warning not cleared");
  remote_deb_a: assert property ($rose(cal_remote) |->
    $past(remote_baseline_request || remote_gain_request, DEB_CYC))
    else $error("remote entry without steady request");

  cover property (status.baseline_trim_active && cal_remote);
  cover property (panel_warning && !relays.conc_relay1 && !relays.conc_relay2);
  cover property (relays.range_relay);
endmodule

bind asal_top asal_top_monitor #(.CW(CW), .DEB_CYC(DEB_CYC)) asal_top_monitor_i (
  .clk, .reset_n, .fault_any, .invalid_fault, .warning_any, .validity_holdoff,
  .reading_valid, .upper_range, .clear_key, .remote_baseline_request,
  .remote_gain_request, .reg_addr, .reg_wdata, .reg_wr, .status, .relays,
  .panel_warning, .cal_remote);

// [tb/asal_plc_model.sv]
// Behavioural controller on the far side: raises remote requests, logs drops.
// Assumes the bench gives one-cycle go pulses on the shared clock.
`timescale 1ns/10ps
module asal_plc_model #(
  parameter int HOLD = 20
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic go_base,
  input  wire logic go_gain,
  input  wire logic health_relay,
  output logic      remote_baseline_request,
  output logic      remote_gain_request,
  output int        drop_cnt
);
  int   hold_q;
  logic last_q;

  // Requests are held well past the debounce window; an open contact reads low.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_q <= 0;
      last_q <= 1'h0;
      drop_cnt <= 0;
      remote_baseline_request <= 1'h0;
      remote_gain_request <= 1'h0;
    end
    else
    begin
      last_q <= health_relay;
      if (last_q && !health_relay)
        drop_cnt <= drop_cnt + 1;
      if (go_base || go_gain)
      begin
        hold_q <= HOLD;
        remote_baseline_request <= go_base;
        remote_gain_request <= go_gain;
      end
      else if (hold_q > 0)
        hold_q <= hold_q - 1;
      else
      begin
        remote_baseline_request <= 1'h0;
        remote_gain_request <= 1'h0;
      end
    end
  end
endmodule

// [tb/asal_top_test.sv]
// Self-checking bench for asal_top with the controller model beside it.
// Assumes a 250 MHz clock and a shortened debounce count.
`timescale 1ns/10ps
module asal_top_test
  import asal_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------
  localparam int DEB = 4;
  logic clk = 1'h0, reset_n = 1'h0, fault_any = 1'h0, invalid_fault = 1'h0;
  logic warning_any = 1'h0, validity_holdoff = 1'h0, reading_valid = 1'h1;
  logic upper_range = 1'h0, local_base_cal = 1'h0, local_gain_cal = 1'h0;
  logic cal_done = 1'h0, clear_key = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic go_base = 1'h0, go_gain = 1'h0, remote_baseline_request, remote_gain_request;
  logic panel_warning, cal_remote, irq;
  logic [15:0] concentration = 16'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  asal_status_t status;
  asal_relay_t  relays;
  int error_cnt = 0, n_tests = 0, cyc = 0, drops;
  logic [15:0] cv [4] = '{16'h64, 16'h65, 16'hC9, 16'h32};
  logic [11:0] ev [4] = '{12'h830, 12'h4B0, 12'h6B0, 12'h0B0};
  wire  [11:0] obs = {relays, panel_warning, cal_remote, status};

  asal_top #(.CW(16), .DEB_CYC(DEB)) asal_top_i (.clk, .reset_n, .fault_any,
    .invalid_fault, .warning_any, .validity_holdoff, .reading_valid, .upper_range,
    .concentration, .local_base_cal, .local_gain_cal, .cal_done, .clear_key,
    .remote_baseline_request, .remote_gain_request, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .status, .relays, .panel_warning, .cal_remote, .irq);
  asal_plc_model asal_plc_model_i (.clk, .reset_n, .go_base, .go_gain,
    .health_relay(relays.health_relay), .remote_baseline_request,
    .remote_gain_request, .drop_cnt(drops));

  initial
  begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
    @(posedge clk);
  endtask

  task automatic st(input logic [11:0] e);
    repeat (2) @(posedge clk);
    #1 chk(32'(obs), 32'(e));
    @(posedge clk);
  endtask

  // Bounded wait for a trim mode to start or end.
  task automatic wait_cal(input logic want);
    int n;
    n = 0;
    #1;
    while ((status.baseline_trim_active | status.gain_trim_active) !== want && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n < 60), 32'h1);
    @(posedge clk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A hang is cut short long after the sequence should have ended.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    rd(ASAL_ADDR_CTRL, 32'h0);
    rd(ASAL_ADDR_SET1, 32'hFFFF);
    rd(ASAL_ADDR_IRQ_MK, 32'h0);
    rd(4'hF, 32'h0);
    st(12'h830);
    rd(ASAL_ADDR_STATE, 32'h830);
    $display("test reset done");
    fault_any <= 1'h1;
    invalid_fault <= 1'h1;
    st(12'h000);
    rd(ASAL_ADDR_IRQ_ST, 32'h1);
    #1 chk(32'(irq), 32'h0);
    wr(ASAL_ADDR_IRQ_MK, 32'h1);
    st(12'h000);
    #1 chk(32'(irq), 32'h1);
    wr(ASAL_ADDR_IRQ_ST, 32'h1);
    st(12'h000);
    #1 chk(32'(irq), 32'h0);
    @(posedge clk);
    fault_any <= 1'h0;
    invalid_fault <= 1'h0;
    validity_holdoff <= 1'h1;
    st(12'h820);
    validity_holdoff <= 1'h0;
    upper_range <= 1'h1;
    wr(ASAL_ADDR_CTRL, 32'h2);
    st(12'h838);
    wr(ASAL_ADDR_CTRL, 32'h1);
    st(12'h938);
    wr(ASAL_ADDR_CTRL, 32'h0);
    st(12'h830);
    upper_range <= 1'h0;
    wr(ASAL_ADDR_CTRL, 32'h4);
    st(12'h031);
    wr(ASAL_ADDR_CTRL, 32'h0);
    st(12'h830);
    warning_any <= 1'h1;
    st(12'h030);
    warning_any <= 1'h0;
    $display("test status done");
    wr(ASAL_ADDR_SET1, 32'h64);
    wr(ASAL_ADDR_SET2, 32'hC8);
    wr(ASAL_ADDR_CTRL, 32'h18);
    for (int i = 0; i < 4; i++)
    begin
      concentration <= cv[i];
      st(ev[i]);
    end
    clear_key <= 1'h1;
    @(posedge clk);
    clear_key <= 1'h0;
    st(12'h830);
    wr(ASAL_ADDR_CTRL, 32'h38);
    concentration <= 16'h96;
    st(12'h2B0);
    concentration <= 16'h0;
    wr(ASAL_ADDR_CLEAR, 32'h1);
    st(12'h830);
    wr(ASAL_ADDR_CTRL, 32'h10);
    concentration <= 16'h96;
    st(12'h830);
    concentration <= 16'h0;
    wr(ASAL_ADDR_CTRL, 32'h0);
    $display("test alarms done");
    wr(ASAL_ADDR_IRQ_ST, 32'hF);
    go_base <= 1'h1;
    @(posedge clk);
    go_base <= 1'h0;
    wait_cal(1'h1);
    st(12'h864);
    wait_cal(1'h0);
    go_gain <= 1'h1;
    @(posedge clk);
    go_gain <= 1'h0;
    wait_cal(1'h1);
    st(12'h862);
    wait_cal(1'h0);
    st(12'h830);
    rd(ASAL_ADDR_IRQ_ST, 32'hC);
    local_base_cal <= 1'h1;
    st(12'h824);
    local_base_cal <= 1'h0;
    cal_done <= 1'h1;
    @(posedge clk);
    cal_done <= 1'h0;
    st(12'h830);
    local_gain_cal <= 1'h1;
    st(12'h822);
    local_gain_cal <= 1'h0;
    cal_done <= 1'h1;
    @(posedge clk);
    cal_done <= 1'h0;
    st(12'h830);
    chk(32'(drops), 32'h5);
    $display("test calibration done");
    summarize();
  end
endmodule
